//--- cps_pkg.sv
package cps_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] CPS_OFF_CMD    = 8'h00;
    localparam logic [7:0] CPS_OFF_ROW0   = 8'h04;
    localparam logic [7:0] CPS_OFF_ROW1   = 8'h08;
    localparam logic [7:0] CPS_OFF_DATA   = 8'h0C;
    localparam logic [7:0] CPS_OFF_STATUS = 8'h10;
    localparam logic [7:0] CPS_OFF_CFG    = 8'h14;
    localparam logic [7:0] CPS_OFF_LEN    = 8'h18;

    // Command register fields
    localparam int CPS_CMD_GO   = 0;
    localparam int CPS_CMD_LAST = 1;
    localparam int CPS_CMD_DUAL = 2;
    localparam int CPS_CMD_STAT = 3;

    // Status register fields (bits 15:8 hold the last status byte)
    localparam int CPS_ST_BUSY      = 0;
    localparam int CPS_ST_RB        = 1;
    localparam int CPS_ST_IN_CACHE  = 2;
    localparam int CPS_ST_ERR_BLOCK = 3;
    localparam int CPS_ST_ERR_DIST  = 4;
    localparam int CPS_ST_ERR_PAGE  = 5;
    localparam int CPS_ST_ERR_ORDER = 6;
    localparam int CPS_ST_BYTE_LO   = 8;

    // Reset values
    localparam logic [15:0] CPS_RST_LEN = 16'h1100;
    localparam logic [23:0] CPS_RST_ROW = 24'h000000;

    // ------------------------------------------------------------------
    // Flash command codes and addressing
    // ------------------------------------------------------------------
    localparam logic [7:0] CPS_OP_SERIAL_IN = 8'h80;
    localparam logic [7:0] CPS_OP_CACHE     = 8'h15;
    localparam logic [7:0] CPS_OP_PROG      = 8'h10;
    localparam logic [7:0] CPS_OP_DUMMY     = 8'h11;
    localparam logic [7:0] CPS_OP_SECOND    = 8'h81;
    localparam logic [7:0] CPS_OP_STAT      = 8'h70;
    localparam logic [7:0] CPS_OP_STAT_MULT = 8'h71;

    localparam int          CPS_ADDR_CYC    = 5;
    localparam int          CPS_PAGE_BITS   = 6;
    localparam int          CPS_PAGES       = 64;
    localparam logic [15:0] CPS_PAGE_BYTES  = 16'h1100;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CPS_CLK_MHZ = 100;
    localparam int CPS_T_PH_NS  = 25;
    localparam int CPS_T_WB_NS  = 100;
    localparam int CPS_T_WHR_NS = 60;
    localparam int CPS_PH_CYC  = (CPS_T_PH_NS * CPS_CLK_MHZ + 999) / 1000;
    localparam int CPS_WB_TICKS =
        (CPS_T_WB_NS * CPS_CLK_MHZ + CPS_PH_CYC * 1000 - 1) / (CPS_PH_CYC * 1000);
    localparam int CPS_WHR_TICKS =
        (CPS_T_WHR_NS * CPS_CLK_MHZ + CPS_PH_CYC * 1000 - 1) / (CPS_PH_CYC * 1000);

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       ce_n;
        logic       cle;
        logic       ale;
        logic       we_n;
        logic       read_strobe_n;
        logic       wp_n;
        logic       io_oe;
        logic [7:0] io_out;
    } cps_pins_s;

    typedef enum logic [4:0] {
        CPS_IDLE, CPS_CMD1, CPS_ADDR1, CPS_DATA1, CPS_CMD11, CPS_GAP11,
        CPS_WAIT11, CPS_CMD81, CPS_ADDR2, CPS_DATA2, CPS_CMDEND, CPS_GAPEND,
        CPS_WAITEND, CPS_STCMD, CPS_STGAP, CPS_STRD
    } cps_state_e;

endpackage

//--- cps_tick_div.sv
`timescale 1ns/10ps
`default_nettype none
module cps_tick_div
    import cps_pkg::*;
#(
    parameter int DIV = CPS_PH_CYC
) (
    input  wire logic i_clk,     // System clock
    input  wire logic i_sys_rst, // Synchronous reset
    input  wire logic i_run,     // Count while high
    output var  logic o_tick     // One-cycle phase pulse
);

    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;
    logic       nxt_tick;

    always_comb begin
        nxt_cnt  = 8'h00;
        nxt_tick = 1'b0;
        if (i_run) begin
            if (cnt_ff == 8'(DIV - 1)) begin
                nxt_tick = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + 8'h01;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cnt_ff <= 8'h00;
            o_tick <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            o_tick <= nxt_tick;
        end
    end

endmodule
`default_nettype wire

//--- cps_cache_prog_host.sv
// Overview of operation
// - 15h after page data starts cached program
// - Block change restarts whole cached sequence; here a start with another block is refused and sets the block error
// - 10h ends sequence; ready means done
// - Full block: 64 page pairs, end 81h-10h
// - At most one block per district
// - Same page address in both districts
// - Sequence 80-addr-data-11-81-addr-data-15/10
// - Only 70h or FFh between 11h and 81h
// - Started sequence allows only own commands
//
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module cps_cache_prog_host
    import cps_pkg::*;
#(
    parameter int PH_DIV = CPS_PH_CYC
) (
    input  wire logic        i_clk,        // 100 MHz clock
    input  wire logic        i_sys_rst,    // Synchronous reset
    input  wire logic        i_wb_cyc,     // Wishbone cycle
    input  wire logic        i_wb_stb,     // Wishbone strobe
    input  wire logic        i_wb_we,      // Wishbone write
    input  wire logic [7:0]  i_wb_adr,     // Byte address
    input  wire logic [3:0]  i_wb_sel,     // Byte lanes
    input  wire logic [31:0] i_wb_dat,     // Write data
    output var  logic [31:0] o_wb_dat,     // Read data
    output var  logic        o_wb_ack,     // Acknowledge
    input  wire logic        i_ready_busy, // Flash ready/busy, high = ready
    input  wire logic [7:0]  i_io_in,      // Flash I/O pins in
    output var  cps_pins_s   o_pins        // Flash control and I/O out
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic       rb_meta_ff;
    logic       rb_ff;
    logic [7:0] io_meta_ff;
    logic [7:0] io_ff;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rb_meta_ff <= 1'b0;
            rb_ff      <= 1'b0;
            io_meta_ff <= 8'h00;
            io_ff      <= 8'h00;
        end else begin
            rb_meta_ff <= i_ready_busy;
            rb_ff      <= rb_meta_ff;
            io_meta_ff <= i_io_in;
            io_ff      <= io_meta_ff;
        end
    end

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    cps_state_e  st_ff,        nxt_st;
    logic [1:0]  ph_ff,        nxt_ph;
    logic [15:0] cnt_ff,       nxt_cnt;
    logic [7:0]  gap_ff,       nxt_gap;
    logic [7:0]  dbyte_ff,     nxt_dbyte;
    logic [7:0]  stat_ff,      nxt_stat;
    logic        in_cache_ff,  nxt_in_cache;
    logic        op_last_ff,   nxt_op_last;
    logic        op_dual_ff,   nxt_op_dual;
    logic [23:0] op_row0_ff,   nxt_op_row0;
    logic [23:0] op_row1_ff,   nxt_op_row1;
    cps_pins_s   nxt_pins;

    logic [3:0]  cmd_ff,       nxt_cmd;
    logic [23:0] row0_ff,      nxt_row0;
    logic [23:0] row1_ff,      nxt_row1;
    logic        wp_off_ff,    nxt_wp_off;
    logic [15:0] len_ff,       nxt_len;
    logic [3:0]  err_ff,       nxt_err;
    logic [31:0] nxt_rdat;
    logic        nxt_ack;

    logic        tick;
    logic        req;
    logic        wr_cmd;
    logic        wr_data;
    logic        start;
    logic        data_taken;
    logic        byte_done;
    logic        bad_dist;
    logic        bad_page;
    logic        bad_block;
    logic        bad_order;
    logic [3:0]  err_set;
    logic        is_cmd;
    logic        is_addr;
    logic        is_data;
    logic        feeding;

    cps_tick_div #(
        .DIV (PH_DIV)
    ) u_tick (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_run     (st_ff != CPS_IDLE),
        .o_tick    (tick)
    );

    // ------------------------------------------------------------------
    // Order checks on a start request
    // ------------------------------------------------------------------
    assign req     = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    assign wr_cmd  = req & i_wb_we & (i_wb_adr == CPS_OFF_CMD) & i_wb_sel[0]
                   & i_wb_dat[CPS_CMD_GO];
    assign wr_data = req & i_wb_we & (i_wb_adr == CPS_OFF_DATA);

    // Block lsb picks the district, so two blocks must differ in it
    assign bad_dist  = i_wb_dat[CPS_CMD_DUAL]
                     & (row0_ff[CPS_PAGE_BITS] == row1_ff[CPS_PAGE_BITS]);
    assign bad_page  = i_wb_dat[CPS_CMD_DUAL]
                     & (row0_ff[CPS_PAGE_BITS-1:0] != row1_ff[CPS_PAGE_BITS-1:0]);
    assign bad_block = in_cache_ff & ~i_wb_dat[CPS_CMD_STAT]
                     & ((row0_ff[23:CPS_PAGE_BITS] != op_row0_ff[23:CPS_PAGE_BITS])
                     | (op_dual_ff
                     & (row1_ff[23:CPS_PAGE_BITS] != op_row1_ff[23:CPS_PAGE_BITS])));
    assign bad_order = (st_ff != CPS_IDLE)
                     | (in_cache_ff & ~i_wb_dat[CPS_CMD_STAT]
                     & (i_wb_dat[CPS_CMD_DUAL] != op_dual_ff));

    assign start   = wr_cmd & ~bad_order
                   & (i_wb_dat[CPS_CMD_STAT] | ~(bad_dist | bad_page | bad_block));
    assign err_set = {wr_cmd & bad_order | wr_data & ~feeding,
                      wr_cmd & ~i_wb_dat[CPS_CMD_STAT] & bad_page,
                      wr_cmd & ~i_wb_dat[CPS_CMD_STAT] & bad_dist,
                      wr_cmd & bad_block};

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    assign byte_done = tick & (ph_ff == 2'd3);
    assign is_cmd    = (st_ff == CPS_CMD1) | (st_ff == CPS_CMD11) | (st_ff == CPS_CMD81)
                     | (st_ff == CPS_CMDEND) | (st_ff == CPS_STCMD);
    assign is_addr   = (st_ff == CPS_ADDR1) | (st_ff == CPS_ADDR2);
    assign is_data   = (st_ff == CPS_DATA1) | (st_ff == CPS_DATA2);
    // Data writes stall from go until their phase, so software needs no timing
    assign feeding   = is_data | (st_ff == CPS_CMD1) | (st_ff == CPS_ADDR1)
                     | (st_ff == CPS_CMD11) | (st_ff == CPS_GAP11) | (st_ff == CPS_WAIT11)
                     | (st_ff == CPS_CMD81) | (st_ff == CPS_ADDR2);

    always_comb begin
        nxt_st       = st_ff;
        nxt_ph       = ph_ff;
        nxt_cnt      = cnt_ff;
        nxt_gap      = gap_ff;
        nxt_dbyte    = dbyte_ff;
        nxt_stat     = stat_ff;
        nxt_in_cache = in_cache_ff;
        nxt_op_last  = op_last_ff;
        nxt_op_dual  = op_dual_ff;
        nxt_op_row0  = op_row0_ff;
        nxt_op_row1  = op_row1_ff;
        data_taken   = 1'b0;
        if (tick && ph_ff != 2'd0) begin
            nxt_ph = ph_ff + 2'd1;
        end
        case (st_ff)
            CPS_IDLE: begin
                if (start) begin
                    nxt_op_dual = i_wb_dat[CPS_CMD_DUAL];
                    nxt_ph      = 2'd1;
                    nxt_cnt     = 16'h0000;
                    if (i_wb_dat[CPS_CMD_STAT]) begin
                        nxt_st = CPS_STCMD;
                    end else begin
                        nxt_op_last  = i_wb_dat[CPS_CMD_LAST];
                        nxt_op_row0  = row0_ff;
                        nxt_op_row1  = row1_ff;
                        nxt_in_cache = ~i_wb_dat[CPS_CMD_LAST];
                        nxt_st       = CPS_CMD1;
                    end
                end
            end
            CPS_CMD1, CPS_CMD81: begin
                if (byte_done) begin
                    nxt_st  = (st_ff == CPS_CMD1) ? CPS_ADDR1 : CPS_ADDR2;
                    nxt_ph  = 2'd1;
                    nxt_cnt = 16'h0000;
                end
            end
            CPS_ADDR1, CPS_ADDR2: begin
                if (byte_done) begin
                    if (cnt_ff == 16'(CPS_ADDR_CYC - 1)) begin
                        nxt_st  = (st_ff == CPS_ADDR1) ? CPS_DATA1 : CPS_DATA2;
                        nxt_ph  = 2'd0;
                        nxt_cnt = 16'h0000;
                    end else begin
                        nxt_ph  = 2'd1;
                        nxt_cnt = cnt_ff + 16'h0001;
                    end
                end
            end
            CPS_DATA1, CPS_DATA2: begin
                if (ph_ff == 2'd0) begin
                    // Bus write is held until its byte is latched: natural back-pressure
                    if (wr_data) begin
                        nxt_dbyte  = i_wb_dat[7:0];
                        nxt_ph     = 2'd1;
                        data_taken = 1'b1;
                    end
                end else if (byte_done) begin
                    nxt_ph = 2'd0;
                    if (cnt_ff == len_ff - 16'h0001) begin
                        nxt_ph  = 2'd1;
                        nxt_cnt = 16'h0000;
                        nxt_st  = (st_ff == CPS_DATA1 && op_dual_ff) ?
                                  CPS_CMD11 : CPS_CMDEND;
                    end else begin
                        nxt_cnt = cnt_ff + 16'h0001;
                    end
                end
            end
            CPS_CMD11: begin
                if (byte_done) begin
                    nxt_st  = CPS_GAP11;
                    nxt_gap = 8'h00;
                end
            end
            CPS_CMDEND: begin
                if (byte_done) begin
                    nxt_st  = CPS_GAPEND;
                    nxt_gap = 8'h00;
                end
            end
            CPS_GAP11, CPS_GAPEND: begin
                if (tick) begin
                    if (gap_ff == 8'(CPS_WB_TICKS - 1)) begin
                        nxt_st = (st_ff == CPS_GAP11) ? CPS_WAIT11 : CPS_WAITEND;
                    end else begin
                        nxt_gap = gap_ff + 8'h01;
                    end
                end
            end
            CPS_WAIT11: begin
                // Nothing is issued here, so no stray command lands before 81h
                if (rb_ff) begin
                    nxt_st = CPS_CMD81;
                    nxt_ph = 2'd1;
                end
            end
            CPS_WAITEND: begin
                // Ready here is cache-ready after 15h, page-done after 10h
                if (rb_ff) begin
                    nxt_st = CPS_STCMD;
                    nxt_ph = 2'd1;
                end
            end
            CPS_STCMD: begin
                if (byte_done) begin
                    nxt_st  = CPS_STGAP;
                    nxt_gap = 8'h00;
                end
            end
            CPS_STGAP: begin
                if (tick) begin
                    if (gap_ff == 8'(CPS_WHR_TICKS - 1)) begin
                        nxt_st = CPS_STRD;
                        nxt_ph = 2'd1;
                    end else begin
                        nxt_gap = gap_ff + 8'h01;
                    end
                end
            end
            CPS_STRD: begin
                if (tick && ph_ff == 2'd2) begin
                    nxt_stat = io_ff;
                end
                if (byte_done) begin
                    nxt_st = CPS_IDLE;
                    nxt_ph = 2'd0;
                end
            end
            default: begin
                nxt_st = CPS_IDLE;
                nxt_ph = 2'd0;
            end
        endcase
    end

    // Pin drive: phase 1 setup, 2 strobe low, 3 hold; the status read strobe is low in phases 1 and 2
    always_comb begin
        nxt_pins               = '0;
        nxt_pins.ce_n          = (st_ff == CPS_IDLE);
        nxt_pins.cle           = is_cmd;
        nxt_pins.ale           = is_addr;
        nxt_pins.wp_n          = wp_off_ff;
        nxt_pins.io_oe         = (is_cmd | is_addr | is_data) & (ph_ff != 2'd0);
        nxt_pins.we_n          = ~(nxt_pins.io_oe & (ph_ff == 2'd2));
        nxt_pins.read_strobe_n = ~((st_ff == CPS_STRD) & ph_ff[1] ^ ph_ff[0]
                                 & (st_ff == CPS_STRD) | (st_ff == CPS_STRD)
                                 & (ph_ff == 2'd2));
        case (st_ff)
            CPS_CMD1:   nxt_pins.io_out = CPS_OP_SERIAL_IN;
            CPS_CMD11:  nxt_pins.io_out = CPS_OP_DUMMY;
            CPS_CMD81:  nxt_pins.io_out = CPS_OP_SECOND;
            CPS_CMDEND: nxt_pins.io_out = op_last_ff ? CPS_OP_PROG : CPS_OP_CACHE;
            CPS_STCMD:  nxt_pins.io_out = op_dual_ff ? CPS_OP_STAT_MULT : CPS_OP_STAT;
            CPS_ADDR1, CPS_ADDR2: begin
                case (cnt_ff[2:0])
                    3'h2:    nxt_pins.io_out = (st_ff == CPS_ADDR1) ? op_row0_ff[7:0]
                                                                    : op_row1_ff[7:0];
                    3'h3:    nxt_pins.io_out = (st_ff == CPS_ADDR1) ? op_row0_ff[15:8]
                                                                    : op_row1_ff[15:8];
                    3'h4:    nxt_pins.io_out = (st_ff == CPS_ADDR1) ? op_row0_ff[23:16]
                                                                    : op_row1_ff[23:16];
                    default: nxt_pins.io_out = 8'h00;
                endcase
            end
            CPS_DATA1, CPS_DATA2: nxt_pins.io_out = dbyte_ff;
            default:    nxt_pins.io_out = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_ff       <= CPS_IDLE;
            ph_ff       <= 2'd0;
            cnt_ff      <= 16'h0000;
            gap_ff      <= 8'h00;
            dbyte_ff    <= 8'h00;
            stat_ff     <= 8'h00;
            in_cache_ff <= 1'b0;
            op_last_ff  <= 1'b0;
            op_dual_ff  <= 1'b0;
            op_row0_ff  <= CPS_RST_ROW;
            op_row1_ff  <= CPS_RST_ROW;
            o_pins      <= '{ce_n: 1'b1, we_n: 1'b1, read_strobe_n: 1'b1, default: '0};
        end else begin
            st_ff       <= nxt_st;
            ph_ff       <= nxt_ph;
            cnt_ff      <= nxt_cnt;
            gap_ff      <= nxt_gap;
            dbyte_ff    <= nxt_dbyte;
            stat_ff     <= nxt_stat;
            in_cache_ff <= nxt_in_cache;
            op_last_ff  <= nxt_op_last;
            op_dual_ff  <= nxt_op_dual;
            op_row0_ff  <= nxt_op_row0;
            op_row1_ff  <= nxt_op_row1;
            o_pins      <= nxt_pins;
        end
    end

    // ------------------------------------------------------------------
    // Wishbone register file
    // ------------------------------------------------------------------
    always_comb begin
        nxt_cmd    = cmd_ff;
        nxt_row0   = row0_ff;
        nxt_row1   = row1_ff;
        nxt_wp_off = wp_off_ff;
        nxt_len    = len_ff;
        nxt_err    = err_ff;
        nxt_rdat   = 32'h00000000;
        nxt_ack    = req & ~(wr_data & feeding);
        if (wr_data && feeding) begin
            nxt_ack = data_taken;
        end
        if (req && i_wb_we) begin
            case (i_wb_adr)
                CPS_OFF_CMD:    if (i_wb_sel[0]) nxt_cmd = i_wb_dat[3:0];
                CPS_OFF_ROW0: begin
                    if (i_wb_sel[0]) nxt_row0[7:0]   = i_wb_dat[7:0];
                    if (i_wb_sel[1]) nxt_row0[15:8]  = i_wb_dat[15:8];
                    if (i_wb_sel[2]) nxt_row0[23:16] = i_wb_dat[23:16];
                end
                CPS_OFF_ROW1: begin
                    if (i_wb_sel[0]) nxt_row1[7:0]   = i_wb_dat[7:0];
                    if (i_wb_sel[1]) nxt_row1[15:8]  = i_wb_dat[15:8];
                    if (i_wb_sel[2]) nxt_row1[23:16] = i_wb_dat[23:16];
                end
                CPS_OFF_STATUS: if (i_wb_sel[0]) nxt_err = err_ff & ~i_wb_dat[6:3];
                CPS_OFF_CFG:    if (i_wb_sel[0]) nxt_wp_off = i_wb_dat[0];
                CPS_OFF_LEN: begin
                    if (i_wb_sel[0]) nxt_len[7:0]  = i_wb_dat[7:0];
                    if (i_wb_sel[1]) nxt_len[15:8] = i_wb_dat[15:8];
                end
                default: nxt_len = len_ff;
            endcase
        end
        // A fresh error outranks a clear in the same cycle
        nxt_err = nxt_err | err_set;
        if (req && !i_wb_we) begin
            case (i_wb_adr)
                CPS_OFF_CMD:    nxt_rdat = {28'h0000000, cmd_ff};
                CPS_OFF_ROW0:   nxt_rdat = {8'h00, row0_ff};
                CPS_OFF_ROW1:   nxt_rdat = {8'h00, row1_ff};
                CPS_OFF_STATUS: nxt_rdat = {16'h0000, stat_ff, 1'b0, err_ff,
                                            in_cache_ff, rb_ff, st_ff != CPS_IDLE};
                CPS_OFF_CFG:    nxt_rdat = {31'h00000000, wp_off_ff};
                CPS_OFF_LEN:    nxt_rdat = {16'h0000, len_ff};
                default:        nxt_rdat = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cmd_ff    <= 4'h0;
            row0_ff   <= CPS_RST_ROW;
            row1_ff   <= CPS_RST_ROW;
            wp_off_ff <= 1'b0;
            len_ff    <= CPS_RST_LEN;
            err_ff    <= 4'h0;
            o_wb_dat  <= 32'h00000000;
            o_wb_ack  <= 1'b0;
        end else begin
            cmd_ff    <= nxt_cmd;
            row0_ff   <= nxt_row0;
            row1_ff   <= nxt_row1;
            wp_off_ff <= nxt_wp_off;
            len_ff    <= nxt_len;
            err_ff    <= nxt_err;
            o_wb_dat  <= nxt_rdat;
            o_wb_ack  <= nxt_ack;
        end
    end

endmodule
`default_nettype wire

//--- cps_cache_prog_host_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module cps_cache_prog_host_asserts
    import cps_pkg::*;
(
    input wire logic        i_clk,        // Clock
    input wire logic        i_sys_rst,    // Reset
    input wire logic        i_wb_cyc,     // Cycle
    input wire logic        i_wb_stb,     // Strobe
    input wire logic [31:0] o_wb_dat,     // Read data
    input wire logic        o_wb_ack,     // Ack
    input wire logic        i_ready_busy, // Ready pin
    input wire cps_pins_s   o_pins        // Flash pins
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held");
    a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
        else $error("ack without request");
    a_dat_quiet: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
        else $error("read data outside ack");
    a_latch_excl: assert property (!(o_pins.cle && o_pins.ale))
        else $error("cle and ale together");
    a_we_sel: assert property (!o_pins.we_n |-> !o_pins.ce_n)
        else $error("write strobe while deselected");
    a_read_ready: assert property (!o_pins.read_strobe_n |->
        i_ready_busy && !o_pins.io_oe)
        else $error("status read while busy or driving");
    a_we_phase: assert property ($fell(o_pins.we_n) |-> !o_pins.we_n[*3] ##1 o_pins.we_n)
        else $error("write strobe width");
    a_rd_width: assert property ($fell(o_pins.read_strobe_n) |->
        !o_pins.read_strobe_n[*6] ##1 o_pins.read_strobe_n)
        else $error("read strobe width");
    a_rst_idle: assert property (disable iff (1'b0) $past(i_sys_rst) |->
        o_pins.ce_n && !o_pins.wp_n)
        else $error("pins not idle in reset");
    cover property ($fell(o_pins.read_strobe_n));
    cover property (o_pins.cle && !o_pins.we_n && o_pins.io_out == CPS_OP_CACHE);
    cover property (o_pins.cle && !o_pins.we_n && o_pins.io_out == CPS_OP_STAT_MULT);
endmodule
bind cps_cache_prog_host cps_cache_prog_host_asserts cps_cache_prog_host_asserts_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_ready_busy(i_ready_busy), .o_pins(o_pins));
`default_nettype wire

//--- cps_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
module cps_flash_model
    import cps_pkg::*;
(
    input  wire logic       i_clk,  // Clock
    input  wire cps_pins_s  i_pins, // Host pins
    input  wire logic [1:0] i_fail, // District fail flags
    output var  logic       o_rb,   // High = ready
    output var  logic [7:0] o_io    // Pins to host
);
    logic [7:0] cmd_ff = 8'hFF, last_ff = 8'h00, st;
    logic [1:0] cur_ff = 2'b00, prv_ff = 2'b00;
    logic       we_d = 1'b1;
    int         busy_ff = 0;
    assign o_rb = (busy_ff == 0);
    assign st = (cmd_ff == 8'h71)
        ? {i_pins.wp_n, o_rb, o_rb, prv_ff, cur_ff, |cur_ff}
        : {i_pins.wp_n, o_rb, o_rb, 3'b000, |prv_ff, |cur_ff};
    // Released bus toggles so a stale byte never looks valid
    assign o_io = i_pins.read_strobe_n ? ~last_ff : st;
    always_ff @(posedge i_clk) begin
        we_d <= i_pins.we_n;
        last_ff <= o_io;
        if (busy_ff != 0) busy_ff <= busy_ff - 1;
        if (i_pins.we_n && !we_d && !i_pins.ce_n && i_pins.cle) begin
            cmd_ff <= i_pins.io_out;
            if (i_pins.io_out inside {8'h15, 8'h10, 8'h11}) busy_ff <= 40;
            if (i_pins.io_out inside {8'h15, 8'h10}) begin
                cur_ff <= i_fail;
                prv_ff <= cur_ff;
            end
        end
    end
endmodule
`default_nettype wire

//--- cps_cache_prog_host_tb.sv
`timescale 1ns/10ps
`default_nettype none
module cps_cache_prog_host_tb;
    import cps_pkg::*;
    logic        i_clk = 0, i_sys_rst = 1, cyc = 0, stb = 0, we = 0, ack, rb;
    logic [7:0]  adr = 8'h00, io;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [1:0]  fail = 2'b00;
    cps_pins_s   pins;
    int          failures = 0, samples_checked = 0;
    cps_cache_prog_host cps_cache_prog_host_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
        .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_ready_busy(rb),
        .i_io_in(io), .o_pins(pins));
    cps_flash_model cps_flash_model_inst (.i_clk(i_clk), .i_pins(pins), .i_fail(fail),
        .o_rb(rb), .o_io(io));
    initial forever #5 i_clk = ~i_clk;
    task automatic print_verdict;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
        do begin
            @(posedge i_clk);
            n++;
        end while (ack !== 1'b1 && n < 3000);
        q = rdat;
        {cyc, stb} <= 2'b00;
        if (n >= 3000) begin
            failures++;
            print_verdict();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        samples_checked++;
        if (q !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, q);
        end
    endtask
    task automatic prog(input logic [23:0] r0, r1, input logic [3:0] c, input int nb);
        int n;
        bus(1'b1, CPS_OFF_ROW0, {8'h00, r0});
        bus(1'b1, CPS_OFF_ROW1, {8'h00, r1});
        bus(1'b1, CPS_OFF_CMD, {28'h0, c});
        for (int i = 0; i < nb; i++) bus(1'b1, CPS_OFF_DATA, 32'(i));
        n = 0;
        do begin
            bus(1'b0, CPS_OFF_STATUS, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 500);
        if (q[0] !== 1'b0) begin
            failures++;
            print_verdict();
        end
    endtask
    initial begin
        repeat (5) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd(CPS_OFF_LEN, 32'h1100, "len");
        rd(8'h1C, 32'h0, "unmapped");
        bus(1'b1, CPS_OFF_LEN, 32'h4);
        bus(1'b1, CPS_OFF_CFG, 32'h1);
        prog(24'h000041, 24'h0, 4'h1, 4);
        rd(CPS_OFF_STATUS, 32'hE006, "cache start");
        prog(24'h000082, 24'h0, 4'h1, 0);
        rd(CPS_OFF_STATUS, 32'hE00E, "block change");
        bus(1'b1, CPS_OFF_STATUS, 32'h78);
        fail <= 2'b01;
        prog(24'h000042, 24'h0, 4'h3, 4);
        rd(CPS_OFF_STATUS, 32'hE102, "cache end");
        fail <= 2'b10;
        prog(24'h000080, 24'h0000C0, 4'h7, 8);
        rd(CPS_OFF_STATUS, 32'hED02, "dual status");
        prog(24'h000080, 24'h000100, 4'h7, 0);
        rd(CPS_OFF_STATUS, 32'hED12, "same district");
        bus(1'b1, CPS_OFF_STATUS, 32'h78);
        prog(24'h000080, 24'h0000C1, 4'h7, 0);
        rd(CPS_OFF_STATUS, 32'hED22, "page mismatch");
        prog(24'h000080, 24'h0, 4'h9, 0);
        rd(CPS_OFF_STATUS, 32'hE322, "status only");
        print_verdict();
    end
endmodule
`default_nettype wire
